// *** hdl/secure_frame_pipeline.sv ***
`timescale 1ns/1ns
module secure_frame_pipeline (
    input  wire logic                            core_clk_i,
    input  wire logic                            nrst_i,
    input  wire logic                            ce_i,
    input  wire logic                            egress_i,
    input  wire logic                            bypass_i,
    input  wire logic                            validate_i,
    input  wire logic                            flow_drop_i,
    input  wire logic                            int_drop_en_i,
    input  wire secure_frame_pkg::tag_mode_t     tag_mode_i,
    input  wire secure_frame_pkg::class_fields_t sa_sel_i,
    input  wire logic [127:0]                    icv_i,
    input  wire logic                            icv_fail_i,
    input  wire logic                            mtu_err_i,
    input  wire secure_frame_pkg::beat_t         in_beat_i,
    input  wire logic                            in_valid_i,
    output logic                                 in_ready_o,
    output secure_frame_pkg::beat_t              out_beat_o,
    output logic                                 out_valid_o,
    input  wire logic                            out_ready_i,
    output secure_frame_pkg::class_fields_t      class_fields_o,
    output logic [7:0]                           short_length_field_o,
    output logic                                 short_length_valid_o,
    output logic                                 icv_err_o,
    output logic                                 len_err_o,
    output logic                                 pause_req_o
);
    secure_frame_pkg::pipe_state_t st_ff, nxt_st;
    secure_frame_pkg::beat_t       out_ff, nxt_out;
    logic                          out_vld_ff, nxt_out_vld;
    logic [15:0]                   cnt_ff, nxt_cnt;
    logic [7:0]                    sl_ff, nxt_sl;
    logic                          sl_got_ff, nxt_sl_got;
    logic                          depad_ff, nxt_depad;
    logic                          drop_ff, nxt_drop;
    logic                          byp_ff, nxt_byp;
    logic [127:0]                  icv_ff, nxt_icv;
    logic [3:0]                    icv_idx_ff, nxt_icv_idx;
    logic                          abort_pend_ff, nxt_abort_pend;
    logic [7:0]                    slf_ff, nxt_slf;
    logic                          slf_vld_ff, nxt_slf_vld;
    logic                          icv_err_ff, nxt_icv_err;
    logic                          len_err_ff, nxt_len_err;
    logic [7:0]                    sectag_off;
    logic                          in_fire, out_free;
    logic                          cur_depad, cur_drop, cur_byp;
    logic [15:0]                   pos, tot, sl_pos, shortfall, frame_len;
    logic                          past_end, last_keep, err_now;

    class_field_sel u_class (
        .core_clk_i   (core_clk_i),
        .nrst_i       (nrst_i),
        .ce_i         (ce_i),
        .tag_mode_i   (tag_mode_i),
        .egress_i     (egress_i),
        .sa_sel_i     (sa_sel_i),
        .fields_o     (class_fields_o),
        .sectag_off_o (sectag_off)
    );

    pause_ctrl u_pause (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .grow_i     (st_ff == secure_frame_pkg::ST_ICV && out_free),
        .slack_i    (!out_vld_ff && out_ready_i),
        .pause_o    (pause_req_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // handshake, per-frame decisions taken on the first byte, and per-byte position and error terms
    always_comb begin
        out_free   = !out_vld_ff || out_ready_i;
        in_ready_o = (st_ff == secure_frame_pkg::ST_HOLD)
                  || (st_ff == secure_frame_pkg::ST_DATA && out_free);
        in_fire    = in_valid_i && in_ready_o;
        cur_byp    = in_beat_i.sof ? bypass_i : byp_ff;
        cur_drop   = in_beat_i.sof ? (flow_drop_i && int_drop_en_i && !bypass_i) : drop_ff;
        cur_depad  = in_beat_i.sof ? (!egress_i && validate_i && !bypass_i
                                      && !(flow_drop_i && int_drop_en_i)) : depad_ff;
        pos        = in_beat_i.sof ? 16'h0000 : cnt_ff;
        sl_pos     = {8'h00, sectag_off} + secure_frame_pkg::SL_BYTE_POS;
        tot        = {8'h00, sectag_off} + secure_frame_pkg::SL_BASE + {8'h00, sl_ff}
                   + secure_frame_pkg::ICV_LEN;
        past_end   = cur_depad && sl_got_ff && pos >= tot;
        last_keep  = cur_depad && sl_got_ff && (pos + secure_frame_pkg::LEN_ONE == tot)
                   && !in_beat_i.eof;
        frame_len  = pos + secure_frame_pkg::LEN_ONE;
        shortfall  = tot - frame_len;
        err_now    = in_beat_i.abort || icv_fail_i || mtu_err_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st         = st_ff;
        nxt_out        = out_ff;
        nxt_out_vld    = out_vld_ff && !out_ready_i;
        nxt_cnt        = cnt_ff;
        nxt_sl         = sl_ff;
        nxt_sl_got     = sl_got_ff;
        nxt_depad      = depad_ff;
        nxt_drop       = drop_ff;
        nxt_byp        = byp_ff;
        nxt_icv        = icv_ff;
        nxt_icv_idx    = icv_idx_ff;
        nxt_abort_pend = abort_pend_ff;
        nxt_slf        = slf_ff;
        nxt_slf_vld    = 1'b0;
        nxt_icv_err    = 1'b0;
        nxt_len_err    = 1'b0;
        case (st_ff)
            secure_frame_pkg::ST_DATA, secure_frame_pkg::ST_HOLD: begin
                if (in_fire) begin
                    nxt_cnt   = frame_len;
                    nxt_depad = cur_depad;
                    nxt_drop  = cur_drop;
                    nxt_byp   = cur_byp;
                    if (in_beat_i.sof) begin
                        nxt_sl_got = 1'b0;
                    end
                    if (cur_depad && pos == sl_pos && in_beat_i.data != 8'h00) begin
                        nxt_sl     = in_beat_i.data;
                        nxt_sl_got = 1'b1;
                    end
                    if (st_ff == secure_frame_pkg::ST_HOLD) begin
                        if (in_beat_i.eof) begin
                            nxt_out.abort = out_ff.abort || err_now;
                            nxt_out_vld   = 1'b1;
                            nxt_st        = secure_frame_pkg::ST_DATA;
                        end
                    end else if (!cur_drop && !past_end) begin
                        nxt_out       = in_beat_i;
                        nxt_out.abort = in_beat_i.eof && err_now;
                        nxt_out_vld   = !last_keep;
                        if (last_keep) begin
                            nxt_out.eof = 1'b1;
                            nxt_st      = secure_frame_pkg::ST_HOLD;
                        end
                        if (in_beat_i.eof && egress_i && !cur_byp) begin
                            nxt_out.eof    = 1'b0;
                            nxt_out.abort  = 1'b0;
                            nxt_icv        = icv_i;
                            nxt_icv_idx    = 4'h0;
                            nxt_abort_pend = err_now;
                            nxt_st         = secure_frame_pkg::ST_ICV;
                            if (frame_len + secure_frame_pkg::ICV_LEN
                                < secure_frame_pkg::MIN_FRAME) begin
                                nxt_slf     = 8'(frame_len - {8'h00, sectag_off}
                                              - secure_frame_pkg::SL_BASE);
                                nxt_slf_vld = 1'b1;
                            end
                        end
                        if (in_beat_i.eof && cur_depad && sl_got_ff && frame_len < tot) begin
                            nxt_out.abort = 1'b1;
                            nxt_icv_err   = shortfall <= secure_frame_pkg::ICV_LEN;
                            nxt_len_err   = shortfall > secure_frame_pkg::ICV_LEN;
                        end
                    end
                end
            end
            secure_frame_pkg::ST_ICV: begin
                if (out_free) begin
                    nxt_out.data  = icv_ff[127:120];
                    nxt_out.sof   = 1'b0;
                    nxt_out.eof   = (icv_idx_ff == secure_frame_pkg::ICV_LAST);
                    nxt_out.abort = (icv_idx_ff == secure_frame_pkg::ICV_LAST) && abort_pend_ff;
                    nxt_out_vld   = 1'b1;
                    nxt_icv       = {icv_ff[119:0], 8'h00};
                    nxt_icv_idx   = icv_idx_ff + 4'h1;
                    if (icv_idx_ff == secure_frame_pkg::ICV_LAST) begin
                        nxt_st = secure_frame_pkg::ST_DATA;
                    end
                end
            end
            default: begin
                nxt_st = secure_frame_pkg::ST_DATA;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff         <= secure_frame_pkg::ST_DATA;
            out_ff        <= '0;
            out_vld_ff    <= 1'b0;
            cnt_ff        <= 16'h0000;
            sl_ff         <= 8'h00;
            sl_got_ff     <= 1'b0;
            depad_ff      <= 1'b0;
            drop_ff       <= 1'b0;
            byp_ff        <= 1'b0;
            icv_ff        <= '0;
            icv_idx_ff    <= 4'h0;
            abort_pend_ff <= 1'b0;
            slf_ff        <= 8'h00;
            slf_vld_ff    <= 1'b0;
            icv_err_ff    <= 1'b0;
            len_err_ff    <= 1'b0;
        end else if (ce_i) begin
            st_ff         <= nxt_st;
            out_ff        <= nxt_out;
            out_vld_ff    <= nxt_out_vld;
            cnt_ff        <= nxt_cnt;
            sl_ff         <= nxt_sl;
            sl_got_ff     <= nxt_sl_got;
            depad_ff      <= nxt_depad;
            drop_ff       <= nxt_drop;
            byp_ff        <= nxt_byp;
            icv_ff        <= nxt_icv;
            icv_idx_ff    <= nxt_icv_idx;
            abort_pend_ff <= nxt_abort_pend;
            slf_ff        <= nxt_slf;
            slf_vld_ff    <= nxt_slf_vld;
            icv_err_ff    <= nxt_icv_err;
            len_err_ff    <= nxt_len_err;
        end
    end

    assign out_beat_o           = out_ff;
    assign out_valid_o          = out_vld_ff;
    assign short_length_field_o = slf_ff;
    assign short_length_valid_o = slf_vld_ff;
    assign icv_err_o            = icv_err_ff;
    assign len_err_o            = len_err_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    abort_on_last_a: assert property (out_valid_o && out_beat_o.abort |-> out_beat_o.eof)
        else $error("abort without end of frame");
    drop_silent_a: assert property (ce_i && in_fire && cur_drop && !out_vld_ff
                                    |=> !out_vld_ff)
        else $error("dropped frame reached output");
    icv_follows_a: assert property (ce_i && in_fire && in_beat_i.eof && egress_i && !cur_byp
                                    && !cur_drop && st_ff == secure_frame_pkg::ST_DATA
                                    |=> st_ff == secure_frame_pkg::ST_ICV)
        else $error("check value not appended");
    icv_stall_a: assert property (st_ff == secure_frame_pkg::ST_ICV |-> !in_ready_o)
        else $error("input taken during check value");
    hold_quiet_a: assert property (st_ff == secure_frame_pkg::ST_HOLD
                                   |-> !out_vld_ff && depad_ff && !byp_ff)
        else $error("held frame visible or not depadded");
    hold_release_a: assert property (ce_i && st_ff == secure_frame_pkg::ST_HOLD && in_fire
                                     && in_beat_i.eof
                                     |=> out_vld_ff && out_ff.eof && st_ff == secure_frame_pkg::ST_DATA)
        else $error("held last byte not released");
    short_err_a: assert property (icv_err_o || len_err_o
                                  |-> !(icv_err_o && len_err_o) && $past(out_free))
        else $error("both short frame errors set");
    icv_len_a: assert property ($rose(st_ff == secure_frame_pkg::ST_ICV)
                                |-> icv_idx_ff == 4'h0)
        else $error("check value index not reset");
endmodule

// *** hdl/secure_frame_pkg.sv ***
package secure_frame_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // one byte beat of the frame stream
    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
        logic       abort;
    } beat_t;

    // fields a secure association may classify on
    typedef struct packed {
        logic da;
        logic sa;
        logic tpid1;
        logic vid1;
        logic tpid2;
        logic vid2;
        logic etype;
        logic label1;
        logic label2;
        logic sectag;
    } class_fields_t;

    typedef enum logic [2:0] {
        TAG_STD   = 3'h0,
        TAG_BYP1  = 3'h1,
        TAG_BYP2  = 3'h2,
        TAG_MPLS1 = 3'h3,
        TAG_MPLS2 = 3'h4
    } tag_mode_t;

    typedef enum logic [2:0] {
        ST_DATA = 3'b001,
        ST_ICV  = 3'b010,
        ST_HOLD = 3'b100
    } pipe_state_t;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  ADDR_PAIR_LEN  = 8'h0C;
    localparam logic [7:0]  VLAN_TAG_LEN   = 8'h04;
    localparam logic [7:0]  MPLS_ETYPE_LEN = 8'h02;
    localparam logic [7:0]  MPLS_LABEL_LEN = 8'h04;
    localparam logic [15:0] SL_BYTE_POS    = 16'h0003;
    localparam logic [15:0] SL_BASE        = 16'h0001;
    localparam logic [15:0] ICV_LEN        = 16'h0010;
    localparam logic [3:0]  ICV_LAST       = 4'hF;
    localparam logic [15:0] MIN_FRAME      = 16'h0040;
    localparam logic [15:0] LEN_ONE        = 16'h0001;
    localparam logic [7:0]  PAUSE_XOFF     = 8'h40;
    localparam logic [7:0]  PAUSE_XON      = 8'h10;
    localparam logic [7:0]  PAUSE_MAX      = 8'hFF;

endpackage

// *** hdl/class_field_sel.sv ***
`timescale 1ns/1ns
module class_field_sel (
    input  wire logic                           core_clk_i,
    input  wire logic                           nrst_i,
    input  wire logic                           ce_i,
    input  wire secure_frame_pkg::tag_mode_t    tag_mode_i,
    input  wire logic                           egress_i,
    input  wire secure_frame_pkg::class_fields_t sa_sel_i,
    output secure_frame_pkg::class_fields_t     fields_o,
    output logic [7:0]                          sectag_off_o
);
    secure_frame_pkg::class_fields_t allow;
    secure_frame_pkg::class_fields_t fields_ff;
    secure_frame_pkg::class_fields_t nxt_fields;
    logic [7:0]                      off_ff;
    logic [7:0]                      nxt_off;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        allow = '0;
        allow.da = 1'b1;
        allow.sa = 1'b1;
        nxt_off = secure_frame_pkg::ADDR_PAIR_LEN;
        case (tag_mode_i)
            secure_frame_pkg::TAG_STD: begin
                allow.tpid1  = egress_i;
                allow.vid1   = egress_i;
                allow.tpid2  = egress_i;
                allow.vid2   = egress_i;
                allow.etype  = egress_i;
                allow.sectag = !egress_i;
            end
            secure_frame_pkg::TAG_BYP1: begin
                allow.tpid1  = 1'b1;
                allow.vid1   = 1'b1;
                allow.tpid2  = egress_i;
                allow.vid2   = egress_i;
                allow.etype  = egress_i;
                allow.sectag = !egress_i;
                nxt_off = secure_frame_pkg::ADDR_PAIR_LEN + secure_frame_pkg::VLAN_TAG_LEN;
            end
            secure_frame_pkg::TAG_BYP2: begin
                allow.tpid1  = 1'b1;
                allow.vid1   = 1'b1;
                allow.tpid2  = 1'b1;
                allow.vid2   = 1'b1;
                allow.etype  = egress_i;
                allow.sectag = !egress_i;
                nxt_off = secure_frame_pkg::ADDR_PAIR_LEN + secure_frame_pkg::VLAN_TAG_LEN
                        + secure_frame_pkg::VLAN_TAG_LEN;
            end
            secure_frame_pkg::TAG_MPLS1, secure_frame_pkg::TAG_MPLS2: begin
                allow.etype  = 1'b1;
                allow.label1 = 1'b1;
                allow.label2 = (tag_mode_i == secure_frame_pkg::TAG_MPLS2);
                allow.sectag = !egress_i;
                nxt_off = secure_frame_pkg::ADDR_PAIR_LEN + secure_frame_pkg::MPLS_ETYPE_LEN
                        + secure_frame_pkg::MPLS_LABEL_LEN;
                if (tag_mode_i == secure_frame_pkg::TAG_MPLS2) begin
                    nxt_off = nxt_off + secure_frame_pkg::MPLS_LABEL_LEN;
                end
            end
            default: begin
                allow = '0;
            end
        endcase
        nxt_fields = allow & sa_sel_i;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fields_ff <= '0;
            off_ff    <= secure_frame_pkg::ADDR_PAIR_LEN;
        end else if (ce_i) begin
            fields_ff <= nxt_fields;
            off_ff    <= nxt_off;
        end
    end

    assign fields_o     = fields_ff;
    assign sectag_off_o = off_ff;
endmodule

// *** hdl/pause_ctrl.sv ***
`timescale 1ns/1ns
module pause_ctrl (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic grow_i,
    input  wire logic slack_i,
    output logic      pause_o
);
    logic [7:0] debt_ff;
    logic [7:0] nxt_debt;
    logic       pause_ff;
    logic       nxt_pause;

    ////////////////////////////////////////////////////////////////////////////
    // expansion debt: added bytes not yet absorbed by idle line slots
    always_comb begin
        nxt_debt = debt_ff;
        if (grow_i && !slack_i && debt_ff != secure_frame_pkg::PAUSE_MAX) begin
            nxt_debt = debt_ff + 8'h01;
        end else if (slack_i && !grow_i && debt_ff != 8'h00) begin
            nxt_debt = debt_ff - 8'h01;
        end
        nxt_pause = pause_ff;
        if (debt_ff >= secure_frame_pkg::PAUSE_XOFF) begin
            nxt_pause = 1'b1;
        end else if (debt_ff <= secure_frame_pkg::PAUSE_XON) begin
            nxt_pause = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            debt_ff  <= 8'h00;
            pause_ff <= 1'b0;
        end else if (ce_i) begin
            debt_ff  <= nxt_debt;
            pause_ff <= nxt_pause;
        end
    end

    assign pause_o = pause_ff;
endmodule

// *** dv/mac_sink_model.sv ***
`timescale 1ns/1ns
module mac_sink_model (
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    slow_i,
    input  wire logic                    valid_i,
    input  wire secure_frame_pkg::beat_t beat_i,
    output logic                         ready_o
);
    secure_frame_pkg::beat_t q[$];

    // slow mode stalls every other cycle
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= slow_i ? ~ready_o : 1'b1;
            if (valid_i && ready_o) begin
                q.push_back(beat_i);
            end
        end
    end
endmodule

// *** dv/tb_secure_frame_pipeline.sv ***
`timescale 1ns/1ns
module tb_secure_frame_pipeline;
    localparam logic [9:0] RX [5] = '{10'h301, 10'h3C1, 10'h3F1, 10'h30D, 10'h30F};
    localparam logic [9:0] TX [5] = '{10'h3F8, 10'h3F8, 10'h3F8, 10'h30C, 10'h30E};
    logic                            core_clk_i, nrst_i, egress, bypass, validate, slow;
    logic                            fdrop, drop_en, icv_fail, mtu_err, in_valid, in_ready;
    logic                            out_valid, out_ready, sl_v, icv_err, len_err, pause;
    logic [127:0]                    icv;
    logic [7:0]                      sl_f, slf_seen;
    secure_frame_pkg::tag_mode_t     tmode;
    secure_frame_pkg::class_fields_t sa_sel, class_f;
    secure_frame_pkg::beat_t         in_beat, out_beat;
    int                              failures, n_tests, cyc, n_icv, n_len;

    secure_frame_pipeline dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .egress_i(egress), .bypass_i(bypass), .validate_i(validate), .flow_drop_i(fdrop),
        .int_drop_en_i(drop_en), .tag_mode_i(tmode), .sa_sel_i(sa_sel), .icv_i(icv),
        .icv_fail_i(icv_fail), .mtu_err_i(mtu_err), .in_beat_i(in_beat), .in_valid_i(in_valid),
        .in_ready_o(in_ready), .out_beat_o(out_beat), .out_valid_o(out_valid),
        .out_ready_i(out_ready), .class_fields_o(class_f), .short_length_field_o(sl_f),
        .short_length_valid_o(sl_v), .icv_err_o(icv_err), .len_err_o(len_err),
        .pause_req_o(pause));
    mac_sink_model mac_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .slow_i(slow),
        .valid_i(out_valid), .beat_i(out_beat), .ready_o(out_ready));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (icv_err === 1'b1) n_icv++;
        if (len_err === 1'b1) n_len++;
        if (sl_v === 1'b1) slf_seen <= sl_f;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // frame without preamble or fcs, byte 15 carries the short length
    task automatic run_frame(input int n, sl, en, input logic [1:0] er, input logic ea);
        int k;
        logic r;
        logic [7:0] d;
        mac_u.q.delete();
        n_icv = 0;
        n_len = 0;
        for (k = 0; k < n; k++) begin
            in_beat  <= '{data: (k == 15) ? sl[7:0] : 8'hA0 + k[7:0], sof: k == 0,
                          eof: k == n - 1, abort: 1'b0};
            in_valid <= 1'b1;
            icv_fail <= er[0] & (k == n - 1);
            mtu_err  <= er[1] & (k == n - 1);
            do begin
                @(negedge core_clk_i);
                r = in_ready;
                @(posedge core_clk_i);
            end while (!r);
        end
        in_valid <= 1'b0;
        icv_fail <= 1'b0;
        mtu_err  <= 1'b0;
        repeat (300) if (mac_u.q.size() < en) @(posedge core_clk_i);
        repeat (30) @(posedge core_clk_i);
        chk("count", en[15:0], 16'(mac_u.q.size()));
        for (k = 0; k < mac_u.q.size() && k < en; k++) begin
            d = (k < n) ? ((k == 15) ? sl[7:0] : 8'hA0 + k[7:0]) : 8'h10 + 8'(k - n);
            chk("beat", {5'h00, d, k == 0, k == en - 1, (k == en - 1) & ea},
                {5'h00, mac_u.q[k]});
        end
    endtask

    task automatic t_egress;
        egress   <= 1'b1;
        validate <= 1'b0;
        run_frame(40, 0, 56, 2'b00, 1'b0);
        chk("short_len", 16'h001B, {8'h00, slf_seen});
        run_frame(4, 0, 20, 2'b00, 1'b0);
        slow <= 1'b1;
        run_frame(4, 0, 20, 2'b01, 1'b1);
        run_frame(1, 0, 17, 2'b10, 1'b1);
        chk("pause", 16'h0000, {15'h0000, pause});
        slow <= 1'b0;
    endtask

    task automatic t_drop;
        egress  <= 1'b0;
        fdrop   <= 1'b1;
        drop_en <= 1'b1;
        run_frame(40, 4, 0, 2'b00, 1'b0);
        drop_en <= 1'b0;
        run_frame(40, 4, 40, 2'b00, 1'b0);
        fdrop   <= 1'b0;
    endtask

    task automatic t_bypass;
        bypass   <= 1'b1;
        validate <= 1'b1;
        egress   <= 1'b1;
        run_frame(40, 4, 40, 2'b00, 1'b0);
        egress   <= 1'b0;
        run_frame(40, 4, 40, 2'b00, 1'b0);
        bypass   <= 1'b0;
    endtask

    task automatic t_depad;
        validate <= 1'b1;
        run_frame(40, 4, 33, 2'b00, 1'b0);
        chk("icv_err", 16'h0000, 16'(n_icv));
        run_frame(30, 4, 30, 2'b00, 1'b1);
        chk("icv_err", 16'h0001, 16'(n_icv));
        run_frame(20, 8, 20, 2'b00, 1'b1);
        chk("len_err", 16'h0001, 16'(n_len));
        validate <= 1'b0;
    endtask

    task automatic t_class;
        int m, d, s;
        logic [9:0] sel;
        for (m = 0; m < 5; m++) begin
            for (d = 0; d < 2; d++) begin
                for (s = 0; s < 2; s++) begin
                    sel = s ? 10'h155 : 10'h3FF;
                    tmode  <= secure_frame_pkg::tag_mode_t'(m[2:0]);
                    egress <= d[0];
                    sa_sel <= sel;
                    repeat (2) @(posedge core_clk_i);
                    @(negedge core_clk_i);
                    chk("class", {6'h00, sel & (d ? TX[m] : RX[m])}, {6'h00, class_f});
                    @(posedge core_clk_i);
                end
            end
        end
        tmode <= secure_frame_pkg::TAG_STD;
    endtask

    initial begin
        {nrst_i, egress, bypass, validate, slow, fdrop, drop_en} = '0;
        {icv_fail, mtu_err, in_valid, in_beat} = '0;
        {failures, n_tests, cyc, n_icv, n_len} = '0;
        slf_seen = '0;
        tmode  = secure_frame_pkg::TAG_STD;
        sa_sel = '1;
        for (int k = 0; k < 16; k++) icv[127 - 8 * k -: 8] = 8'h10 + 8'(k);
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        t_class();
        t_egress();
        t_drop();
        t_bypass();
        t_depad();
        conclude();
    end
endmodule
